// ===== core/floppy_host_mode_status.v
// Notes on behaviour
// R1: config pair at 3F0/3F1 or 370/371, write only, edits only in config state
// R2: controller disabled after reset until block enabled; it then decodes at the reset base 00 until base programmed
// R3: every host register is 8 bits, reached by programmed I/O cycles
// R4: floppy mode bit 0 normal tape layout, 1 enhanced layout
// R5: ident=1, encoding=1 gives AT mode: DMA enable honoured, TC/density high
// R6: ident=0, encoding=1 gives gen2 mode: DMA enable ignored, TC/density low
// R7: both 0 gives model 30 mode: DMA enable honoured, TC high, density low
// R8: offsets +0..+7 decode to status, control, data and reserved registers
// R9: status A readable in non-AT modes; AT-mode read leaves data undriven
// R10: gen2 status A bit 0 is step direction, 1 inward
// R11: gen2 status A bit 1 is inverted write protect, honouring forced protect
// R12: gen2 status A bit 2 shows index input in inverted polarity
// R13: gen2 status A bit 3 shows head side select in true polarity
// R14: gen2 status A bit 4 shows track zero input inverted
// R15: gen2 status A bit 5 shows step output in true polarity
// R16: gen2 status A bit 6 shows second drive present input inverted
// R17: status A bit 7 reads 1 while floppy interrupt asserted
// R18: decode only when enabled, address matches base plus offset, AEN low
`timescale 1ns/1ps
`include "floppy_host_defines.vh"
module floppy_host_mode_status #(
    parameter ADDR_W = 16
) (
    // clock and reset
    input  wire              clk_in,
    input  wire              nrst_in,
    // ISA host bus pins
    input  wire [ADDR_W-1:0] addr_in,
    input  wire [7:0]        data_in,
    input  wire              aen_in,
    input  wire              ior_n_in,
    input  wire              iow_n_in,
    output reg  [7:0]        data_out,
    output reg               data_oe_out,
    // strap choosing the alternate configuration port
    input  wire              cfg_port_sel_in,
    // drive interface pins
    input  wire              disk_protect_n_in,
    input  wire              index_pulse_n_in,
    input  wire              track_zero_n_in,
    input  wire              second_drive_present_n_in,
    input  wire              tc_in,
    // controller core state, same clock
    input  wire              step_dir_in,
    input  wire              head_side_select_in,
    input  wire              step_in,
    input  wire              irq_in,
    input  wire              drq_in,
    input  wire              density_in,
    input  wire [7:0]        core_rd_data_in,
    // register strobes towards the controller core
    output reg  [7:0]        read_strobe_out,
    output reg  [7:0]        write_strobe_out,
    output reg  [7:0]        write_data_out,
    // mode and control outputs
    output reg  [7:0]        digital_output_out,
    output reg  [1:0]        interface_mode_out,
    output reg               enhanced_mode_out,
    output reg               config_active_out,
    output reg               floppy_irq_out,
    output reg               floppy_irq_oe_out,
    output reg               dma_request_out,
    output reg               dma_request_oe_out,
    output reg               terminal_count_out,
    output reg               density_select_out
);

    localparam SW = ADDR_W + 17;
    localparam [1:0] CST_IDLE   = 2'h0;
    localparam [1:0] CST_KEY1   = 2'h1;
    localparam [1:0] CST_ACTIVE = 2'h2;

    // pin synchronisers
    wire [SW-1:0] pins_raw;
    wire [SW-1:0] pins_s;

    assign pins_raw = {cfg_port_sel_in, tc_in, second_drive_present_n_in,
                       track_zero_n_in, index_pulse_n_in, disk_protect_n_in,
                       iow_n_in, ior_n_in, aen_in, data_in, addr_in};

    sync_bits #(
        .WIDTH (SW)
    ) u_sync (
        .clk_in   (clk_in),
        .async_in (pins_raw),
        .sync_out (pins_s)
    );

    wire [ADDR_W-1:0] addr_s  = pins_s[ADDR_W-1:0];
    wire [7:0]        data_s  = pins_s[ADDR_W+7:ADDR_W];
    wire              aen_s   = pins_s[ADDR_W+8];
    wire              ior_n_s = pins_s[ADDR_W+9];
    wire              iow_n_s = pins_s[ADDR_W+10];
    wire              wp_n_s  = pins_s[ADDR_W+11];
    wire              idx_n_s = pins_s[ADDR_W+12];
    wire              trk_n_s = pins_s[ADDR_W+13];
    wire              drv2_n_s = pins_s[ADDR_W+14];
    wire              tc_s    = pins_s[ADDR_W+15];
    wire              strap_s = pins_s[ADDR_W+16];

    // state
    reg               ior_prev;
    reg               iow_prev;
    reg               strap_taken;
    reg               alt_port;
    reg [1:0]         cfg_state;
    reg [7:0]         cfg_index;
    reg [7:0]         cfg_enable;
    reg [7:0]         cfg_base;
    reg [7:0]         cfg_mode;
    reg [7:0]         cfg_force;
    reg               step_prev;
    reg               step_latch;

    // bus decode
    wire [ADDR_W-1:0] cfg_port  = alt_port ? `CFG_PORT_ALT : `CFG_PORT_PRI;
    wire [ADDR_W-1:0] cfg_portd = cfg_port + {{(ADDR_W-1){1'b0}}, 1'b1};
    wire              rd_fall   = ior_prev & ~ior_n_s;
    wire              wr_rise   = ~iow_prev & iow_n_s;
    wire              cfg_hit_i = ~aen_s & (addr_s == cfg_port);
    wire              cfg_hit_d = ~aen_s & (addr_s == cfg_portd);
    wire              fdc_hit   = cfg_enable[`CFG_ENABLE_BIT] & ~aen_s &
                                  (~|addr_s[ADDR_W-1:11]) &
                                  (addr_s[10:3] == cfg_base); // R2 R18
    wire [2:0]        offset    = addr_s[2:0];

    // interface mode from configuration
    wire              ident     = cfg_mode[`MODE_IDENT_BIT];
    wire              encoding_mode_bit       = cfg_mode[`MODE_MFM_BIT];
    wire [1:0]        ifm       = (ident & encoding_mode_bit)  ? `IFM_AT :   // R5
                                  (!ident & encoding_mode_bit) ? `IFM_GEN2 : // R6
                                  `IFM_M30;                    // R7
    wire              dma_on    = (ifm == `IFM_GEN2) |
                                  digital_output_out[`DOR_DMAEN_BIT];

    // status A layouts
    wire              wp_eff_n  = wp_n_s & ~cfg_force[`FORCE_WP_BIT]; // R11
    wire [7:0]        sta_gen2  = {irq_in,          // R17
                                   drv2_n_s,        // R16
                                   step_in,         // R15
                                   trk_n_s,         // R14
                                   head_side_select_in, // R13
                                   idx_n_s,         // R12
                                   wp_eff_n,        // R11
                                   step_dir_in};    // R10
    wire [7:0]        sta_m30   = {irq_in, drq_in, step_latch, ~trk_n_s,
                                   ~head_side_select_in, ~idx_n_s,
                                   ~wp_eff_n, ~step_dir_in};

    // read data path, 8 bits per register
    reg  [7:0]        next_data;
    reg               next_oe;

    always @* begin
        next_data = 8'h00;
        next_oe   = ~ior_n_s & fdc_hit;
        case (offset)
            `OFS_STATUS_A: begin
                next_data = (ifm == `IFM_GEN2) ? sta_gen2 : sta_m30;
                if (ifm == `IFM_AT) begin
                    next_oe = 1'b0; // R9
                end
            end
            `OFS_DIG_OUT: begin
                next_data = digital_output_out;
            end
            `OFS_RESERVED: begin
                next_oe = 1'b0; // R8
            end
            default: begin
                next_data = core_rd_data_in; // R8
            end
        endcase
    end

    // strobes towards the core, one per offset
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_strobe
            always @(posedge clk_in) begin
                if (!nrst_in) begin
                    read_strobe_out[g]  <= 1'b0;
                    write_strobe_out[g] <= 1'b0;
                end else begin
                    read_strobe_out[g]  <= rd_fall & fdc_hit &
                                           (offset == g); // R8
                    write_strobe_out[g] <= wr_rise & fdc_hit &
                                           (offset == g); // R8
                end
            end
        end
    endgenerate

    // strap capture at reset release
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            strap_taken <= 1'b0;
            alt_port    <= 1'b0;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            alt_port    <= strap_s; // R1
        end
    end

    // configuration state machine and registers; the port is write only
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            cfg_state  <= CST_IDLE;
            cfg_index  <= 8'h00;
            cfg_enable <= `CFG_ENABLE_RST; // R2
            cfg_base   <= `CFG_BASE_RST;
            cfg_mode   <= `CFG_MODE_RST;
            cfg_force  <= `CFG_FORCE_RST;
        end else if (wr_rise && cfg_hit_i) begin
            case (cfg_state)
                CST_IDLE: begin
                    if (data_s == `CFG_ENTER_KEY) begin
                        cfg_state <= CST_KEY1;
                    end
                end
                CST_KEY1: begin
                    if (data_s == `CFG_ENTER_KEY) begin
                        cfg_state <= CST_ACTIVE;
                    end else begin
                        cfg_state <= CST_IDLE;
                    end
                end
                CST_ACTIVE: begin
                    if (data_s == `CFG_EXIT_KEY) begin
                        cfg_state <= CST_IDLE;
                    end else begin
                        cfg_index <= data_s;
                    end
                end
                default: begin
                    cfg_state <= CST_IDLE;
                end
            endcase
        end else if (wr_rise && cfg_hit_d && cfg_state == CST_ACTIVE) begin
            case (cfg_index) // R1
                `CFG_IDX_ENABLE: cfg_enable <= data_s;
                `CFG_IDX_BASE:   cfg_base   <= data_s;
                `CFG_IDX_MODE:   cfg_mode   <= data_s; // R4
                `CFG_IDX_FORCE:  cfg_force  <= data_s;
                default:         cfg_index  <= cfg_index;
            endcase
        end
    end

    // bus edges, step latch and digital output register
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            ior_prev           <= 1'b1;
            iow_prev           <= 1'b1;
            step_prev          <= 1'b0;
            step_latch         <= 1'b0;
            digital_output_out <= `DOR_RST;
        end else begin
            ior_prev  <= ior_n_s;
            iow_prev  <= iow_n_s;
            step_prev <= step_in;
            // a new step wins over a clearing read of digital input
            if (step_in && !step_prev) begin
                step_latch <= 1'b1;
            end else if (rd_fall && fdc_hit && offset == `OFS_DIG_IN) begin
                step_latch <= 1'b0;
            end
            if (wr_rise && fdc_hit && offset == `OFS_DIG_OUT) begin
                digital_output_out <= data_s; // R3
            end
        end
    end

    // registered outputs
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            data_out           <= 8'h00;
            data_oe_out        <= 1'b0;
            write_data_out     <= 8'h00;
            interface_mode_out <= `IFM_AT;
            enhanced_mode_out  <= 1'b0;
            config_active_out  <= 1'b0;
            floppy_irq_out     <= 1'b0;
            floppy_irq_oe_out  <= 1'b0;
            dma_request_out    <= 1'b0;
            dma_request_oe_out <= 1'b0;
            terminal_count_out <= 1'b0;
            density_select_out <= 1'b0;
        end else begin
            data_out           <= next_data;
            data_oe_out        <= next_oe; // R9
            write_data_out     <= data_s;
            interface_mode_out <= ifm;
            enhanced_mode_out  <= cfg_mode[`MODE_ENH_BIT]; // R4
            config_active_out  <= (cfg_state == CST_ACTIVE);
            floppy_irq_out     <= irq_in;
            dma_request_out    <= drq_in;
            floppy_irq_oe_out  <= dma_on; // R5 R6 R7
            dma_request_oe_out <= dma_on; // R5 R6 R7
            terminal_count_out <= dma_on &
                                  ((ifm == `IFM_GEN2) ? ~tc_s : tc_s); // R6
            density_select_out <= (ifm == `IFM_AT) ? density_in
                                                   : ~density_in; // R5 R7
        end
    end

endmodule // floppy_host_mode_status

// ===== core/floppy_host_defines.vh
`ifndef FLOPPY_HOST_DEFINES_VH
`define FLOPPY_HOST_DEFINES_VH

// configuration port pair, selected by strap at reset release
`define CFG_PORT_PRI    16'h03F0
`define CFG_PORT_ALT    16'h0370

// configuration state entry and exit keys, written to the index port
`define CFG_ENTER_KEY   8'h55
`define CFG_EXIT_KEY    8'hAA

// configuration register indices
`define CFG_IDX_ENABLE  8'h00
`define CFG_IDX_BASE    8'h01
`define CFG_IDX_MODE    8'h02
`define CFG_IDX_FORCE   8'h03

// configuration field positions
`define CFG_ENABLE_BIT  0
`define MODE_IDENT_BIT  1
`define MODE_MFM_BIT    2
`define MODE_ENH_BIT    3
`define FORCE_WP_BIT    0

// configuration reset values
`define CFG_ENABLE_RST  8'h00
`define CFG_BASE_RST    8'h00
`define CFG_MODE_RST    8'h06
`define CFG_FORCE_RST   8'h00

// controller register offsets from the programmed base
`define OFS_STATUS_A    3'h0
`define OFS_STATUS_B    3'h1
`define OFS_DIG_OUT     3'h2
`define OFS_TAPE        3'h3
`define OFS_MAIN_STAT   3'h4
`define OFS_DATA_QUEUE  3'h5
`define OFS_RESERVED    3'h6
`define OFS_DIG_IN      3'h7

// digital output register
`define DOR_DMAEN_BIT   3
`define DOR_RST         8'h00

// interface mode codes
`define IFM_AT          2'h0
`define IFM_GEN2        2'h1
`define IFM_M30         2'h2

`endif

// ===== core/sync_bits.v
`timescale 1ns/1ps
module sync_bits #(
    parameter WIDTH = 8
) (
    // clock
    input  wire             clk_in,
    // asynchronous inputs and their synchronised copies
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta;

    // two stages; the first stage feeds only the second
    always @(posedge clk_in) begin
        meta     <= async_in;
        sync_out <= meta;
    end

endmodule // sync_bits

// ===== sim/floppy_host_mode_status_asserts.sv
`timescale 1ns/1ps
`include "floppy_host_defines.vh"
module floppy_host_mode_status_asserts (
    // clock, reset and bus pins
    input wire logic       clk_in,
    input wire logic       nrst_in,
    input wire logic       aen_in,
    input wire logic       ior_n_in,
    input wire logic       data_oe_out,
    // drive and core levels
    input wire logic       density_in,
    input wire logic       tc_in,
    input wire logic       irq_in,
    input wire logic       drq_in,
    // observed outputs
    input wire logic [7:0] read_strobe_out,
    input wire logic [7:0] write_strobe_out,
    input wire logic [7:0] write_data_out,
    input wire logic [7:0] digital_output_out,
    input wire logic [1:0] interface_mode_out,
    input wire logic       config_active_out,
    input wire logic       floppy_irq_oe_out,
    input wire logic       dma_request_oe_out,
    input wire logic       density_select_out,
    input wire logic       terminal_count_out,
    input wire logic       floppy_irq_out,
    input wire logic       dma_request_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    wire gen2 = interface_mode_out == `IFM_GEN2;
    AST_RST: assert property (disable iff (1'b0) !nrst_in |=> !data_oe_out
        && !config_active_out && interface_mode_out == `IFM_AT)
        else $error("outputs not cleared by reset");
    AST_NO_AEN: assert property (aen_in[*5] |-> !data_oe_out)
        else $error("data driven during dma cycle");
    AST_OE_RISE: assert property ($rose(data_oe_out) |->
        !$past(ior_n_in) && !aen_in)
        else $error("data driven without read strobe");
    AST_GEN2_OE: assert property (gen2[*2] |->
        floppy_irq_oe_out && dma_request_oe_out)
        else $error("irq or drq floating in gen2 mode");
    AST_DMAEN_OE: assert property ((!gen2 && !digital_output_out[3])[*2] |->
        !floppy_irq_oe_out && !dma_request_oe_out)
        else $error("irq or drq driven with dma disabled");
    AST_DENS: assert property (($stable(density_in)
        && $stable(interface_mode_out))[*3] |-> density_select_out ==
        (interface_mode_out == `IFM_AT ? density_in : !density_in))
        else $error("density select polarity wrong");
    AST_TC_GEN2: assert property (($stable(tc_in) && gen2)[*5] |->
        terminal_count_out == !tc_in)
        else $error("terminal count polarity wrong");
    AST_DOR: assert property (write_strobe_out[2] |->
        digital_output_out == write_data_out)
        else $error("digital output not loaded");
    AST_WPULSE: assert property (write_strobe_out != 8'h00 |=>
        write_strobe_out == 8'h00)
        else $error("write strobe longer than one cycle");
    AST_RPULSE: assert property (read_strobe_out != 8'h00 |=>
        read_strobe_out == 8'h00)
        else $error("read strobe longer than one cycle");
    AST_RD_OE: assert property ($rose(data_oe_out) |->
        $onehot(read_strobe_out))
        else $error("data driven without a register read strobe");
    AST_IRQ_COPY: assert property (nrst_in |=>
        floppy_irq_out == $past(irq_in))
        else $error("interrupt output does not follow core");
    AST_DRQ_COPY: assert property (nrst_in |=>
        dma_request_out == $past(drq_in))
        else $error("dma request output does not follow core");
endmodule // floppy_host_mode_status_asserts

// ===== sim/isa_host_model.sv
`timescale 1ns/1ps
module isa_host_model (
    // bus answer from the device
    input  wire logic        clk_in,
    input  wire logic [7:0]  rd_data_in,
    input  wire logic        rd_oe_in,
    // bus pins driven by the host
    output logic      [15:0] addr_out,
    output logic      [7:0]  data_out,
    output logic             aen_out,
    output logic             ior_n_out,
    output logic             iow_n_out
);
    initial begin
        addr_out = 16'h0000;
        data_out = 8'h00;
        aen_out = 1'b0;
        ior_n_out = 1'b1;
        iow_n_out = 1'b1;
    end
    // strobe held 4 clocks, address and data 4 more; released lines invert
    task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_in);
        addr_out = a;
        data_out = d;
        iow_n_out = 1'b0;
        repeat (4) @(negedge clk_in);
        iow_n_out = 1'b1;
        repeat (4) @(negedge clk_in);
        addr_out = ~a;
        data_out = ~d;
    endtask
    task automatic io_rd(input logic [15:0] a, input logic dma,
                         output logic [7:0] d, output logic oe);
        @(negedge clk_in);
        addr_out = a;
        aen_out = dma;
        ior_n_out = 1'b0;
        repeat (5) @(negedge clk_in);
        d = rd_data_in;
        oe = rd_oe_in;
        ior_n_out = 1'b1;
        repeat (4) @(negedge clk_in);
        addr_out = ~a;
        aen_out = 1'b0;
    endtask
endmodule // isa_host_model

// ===== sim/floppy_host_mode_status_tb.sv
`timescale 1ns/1ps
`include "floppy_host_defines.vh"
module floppy_host_mode_status_tb;
    localparam logic [15:0] BASE = 16'h01F0;
    logic clk_in = 0, nrst_in = 0, sel = 0, tc = 0, den = 0, oe, aen;
    logic wp_n = 1, idx_n = 1, trk_n = 1, drv_n = 1, dir = 0, hs = 0;
    logic stp = 0, irq = 0, drq = 0, ior_n, iow_n, dm_oe, enh, cfga;
    logic fi, fioe, dq, dqoe, tco, dso;
    logic [15:0] addr;
    logic [7:0] wdata, rdata, core_rd = 8'h00, dout, rstb, wstb, wdat, digital_output;
    logic [1:0] ifm;
    int fail_count = 0, checks = 0, cycles = 0;
    always #4 clk_in = ~clk_in;
    isa_host_model host (.clk_in(clk_in), .rd_data_in(dout),
        .rd_oe_in(dm_oe), .addr_out(addr), .data_out(wdata),
        .aen_out(aen), .ior_n_out(ior_n), .iow_n_out(iow_n));
    floppy_host_mode_status uut (.clk_in(clk_in), .nrst_in(nrst_in),
        .addr_in(addr), .data_in(wdata), .aen_in(aen), .ior_n_in(ior_n),
        .iow_n_in(iow_n), .data_out(dout), .data_oe_out(dm_oe),
        .cfg_port_sel_in(sel), .disk_protect_n_in(wp_n),
        .index_pulse_n_in(idx_n), .track_zero_n_in(trk_n),
        .second_drive_present_n_in(drv_n), .tc_in(tc),
        .step_dir_in(dir), .head_side_select_in(hs), .step_in(stp),
        .irq_in(irq), .drq_in(drq), .density_in(den),
        .core_rd_data_in(core_rd), .read_strobe_out(rstb),
        .write_strobe_out(wstb), .write_data_out(wdat),
        .digital_output_out(digital_output), .interface_mode_out(ifm),
        .enhanced_mode_out(enh), .config_active_out(cfga),
        .floppy_irq_out(fi), .floppy_irq_oe_out(fioe),
        .dma_request_out(dq), .dma_request_oe_out(dqoe),
        .terminal_count_out(tco), .density_select_out(dso));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic rd(input logic [15:0] a);
        host.io_rd(a, 1'b0, rdata, oe);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        host.io_wr(a, d);
    endtask
    task automatic cfg(input logic [7:0] idx, input logic [7:0] val);
        wr(16'h03F0, idx);
        wr(16'h03F1, val);
    endtask
    task automatic enter();
        wr(16'h03F0, `CFG_ENTER_KEY);
        wr(16'h03F0, `CFG_ENTER_KEY);
    endtask
    task automatic set_mode(input logic [7:0] m);
        enter();
        cfg(`CFG_IDX_MODE, m);
        wr(16'h03F0, `CFG_EXIT_KEY);
        repeat (6) @(negedge clk_in);
    endtask
    task automatic t_disabled();
        rd(BASE);
        check(8'(oe), 8'h00);
        check(8'(ifm), 8'(`IFM_AT));
    endtask
    task automatic t_config();
        enter();
        check(8'(cfga), 8'h01);
        rd(16'h03F1);
        check(8'(oe), 8'h00);
        cfg(`CFG_IDX_BASE, 8'h3E);
        cfg(`CFG_IDX_ENABLE, 8'h01);
        set_mode(8'h04);
        check(8'(cfga), 8'h00);
        check(8'(ifm), 8'(`IFM_GEN2));
        den = 1;
        repeat (6) @(negedge clk_in);
        check({fioe, dqoe, dso, tco}, 8'h0D);
    endtask
    task automatic t_status_a(input logic [7:0] p);
        {irq, drv_n, stp, trk_n, hs, idx_n, wp_n, dir} = p;
        repeat (6) @(negedge clk_in);
        rd(BASE);
        check(8'(oe), 8'h01);
        check(rdata, p);
    endtask
    task automatic t_force_wp();
        enter();
        cfg(`CFG_IDX_FORCE, 8'h01);
        wr(16'h03F0, `CFG_EXIT_KEY);
        rd(BASE);
        check(rdata & 8'h02, 8'h00);
    endtask
    task automatic t_decode();
        rd(BASE + 16'h0006);
        check(8'(oe), 8'h00);
        host.io_rd(BASE, 1'b1, rdata, oe);
        check(8'(oe), 8'h00);
        rd(BASE + 16'h0008);
        check(8'(oe), 8'h00);
        core_rd = 8'hC3;
        rd(BASE + 16'h0001);
        check({oe, rdata}, 9'h1C3);
        wr(BASE + 16'h0002, 8'h08);
        check(digital_output, 8'h08);
    endtask
    task automatic t_modes();
        set_mode(8'h00);
        check(8'(ifm), 8'(`IFM_M30));
        check({fioe, dso}, 8'h02);
        drq = 1;
        rd(BASE);
        check(rdata, 8'h67);
        rd(BASE + 16'h0007);
        rd(BASE);
        check(rdata, 8'h47);
        wr(BASE + 16'h0002, 8'h00);
        repeat (3) @(negedge clk_in);
        check(8'(fioe), 8'h00);
        set_mode(8'h0E);
        check({enh, ifm}, {5'h00, 1'b1, `IFM_AT});
        rd(BASE);
        check(8'(oe), 8'h00);
        wr(BASE + 16'h0002, 8'h08);
        tc = 1;
        repeat (6) @(negedge clk_in);
        check({fioe, dso, tco}, 8'h07);
    endtask
    task automatic t_alt_port();
        sel = 1;
        nrst_in = 0;
        repeat (12) @(negedge clk_in);
        nrst_in = 1;
        repeat (4) @(negedge clk_in);
        check({digital_output, 6'(ifm)}, 14'h0000);
        rd(BASE);
        check(8'(oe), 8'h00);
        enter();
        check(8'(cfga), 8'h00);
        wr(16'h0370, `CFG_ENTER_KEY);
        wr(16'h0370, `CFG_ENTER_KEY);
        check(8'(cfga), 8'h01);
        wr(16'h0370, `CFG_EXIT_KEY);
        check(8'(cfga), 8'h00);
    endtask
    initial begin
        repeat (12) @(negedge clk_in);
        nrst_in = 1;
        repeat (4) @(negedge clk_in);
        t_disabled();
        t_config();
        t_status_a(8'hA5);
        t_status_a(8'h5A);
        t_force_wp();
        t_decode();
        t_modes();
        t_alt_port();
        report_and_stop();
    end
endmodule // floppy_host_mode_status_tb
bind floppy_host_mode_status floppy_host_mode_status_asserts chk (
    .clk_in(clk_in), .nrst_in(nrst_in), .aen_in(aen_in),
    .ior_n_in(ior_n_in), .data_oe_out(data_oe_out),
    .density_in(density_in), .tc_in(tc_in),
    .irq_in(irq_in), .drq_in(drq_in),
    .read_strobe_out(read_strobe_out),
    .floppy_irq_out(floppy_irq_out),
    .dma_request_out(dma_request_out),
    .write_strobe_out(write_strobe_out), .write_data_out(write_data_out),
    .digital_output_out(digital_output_out),
    .interface_mode_out(interface_mode_out),
    .config_active_out(config_active_out),
    .floppy_irq_oe_out(floppy_irq_oe_out),
    .dma_request_oe_out(dma_request_oe_out),
    .density_select_out(density_select_out),
    .terminal_count_out(terminal_count_out));
